// file: hw/fbm_top.sv
// job handler: parameter list, echo list, version, diagnostics, slave status
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata_q,
	output logic irq_q,
	// parameter send to slaves
	output logic param_req_q,
	output logic [4:0] param_addr_q,
	output logic [3:0] param_data_q,
	input wire logic param_ack,
	input wire logic [3:0] param_echo,
	// slave status fetch, slave clears its register on fetch
	output logic status_req_q,
	output logic [4:0] status_addr_q,
	input wire logic status_ack,
	input wire logic addr_volatile_flag,
	input wire logic parity_err_flag,
	input wire logic end_bit_err_flag,
	input wire logic nvm_read_err_flag,
	// data exchange error reports
	input wire logic xfer_fail,
	input wire logic [4:0] xfer_fail_addr,
	input wire logic slave_active,
	input wire logic [31:0] detected_slave_list
);
	import fbm_pkg::*;

	fbm_state_t state_q;
	logic [3:0] act_q [0:31];
	logic [3:0] new_q [0:31];
	logic [3:0] echo_q [0:31];
	logic [3:0] cmd_q;
	logic [3:0] idx_q;
	logic [3:0] job_word_count;
	logic [4:0] walk_q;
	logic [15:0] job_last_q;
	logic [15:0] rep_word_q;
	logic [1:0] istat_q;
	logic [1:0] imask_q;
	logic [7:0] err_rdata;
	logic job_wr;
	logic job_ok;
	logic job_bad;
	logic rep_rd;
	logic done_ev;
	logic err_inc;
	logic walk_hit;
	logic walk_end;
	logic [15:0] rep_word;
	logic [3:0] flags;

	////////////////////////////////////////////////////////////////////////////////
	// job decode

	assign job_wr = wr && addr == `FBM_A_JOB && state_q == FBM_IDLE;
	always_comb begin
		job_ok = 1'b0;
		if (wdata[15:12] == `FBM_MARK_REQ) begin
			case (wdata[11:8])
				`FBM_CMD_PLIST, `FBM_CMD_ECHO, `FBM_CMD_VER: job_ok = 1'b1;
				`FBM_CMD_DIAG, `FBM_CMD_STAT: job_ok = 1'b1;
				default: job_ok = 1'b0;
			endcase
		end
	end
	assign job_bad = job_wr && !job_ok;
	assign rep_rd = rd && addr == `FBM_A_REPLY && state_q == FBM_REPLY;
	assign walk_hit = new_q[walk_q] != act_q[walk_q];
	assign walk_end = walk_q == `FBM_LAST_SLAVE;
	assign done_ev = (state_q == FBM_PWALK && walk_end && !walk_hit)
		|| (state_q == FBM_PWAIT && param_ack && walk_end)
		|| (state_q == FBM_DIAG) || (state_q == FBM_STWAIT && status_ack)
		|| (job_wr && job_ok && (wdata[11:8] == `FBM_CMD_ECHO || wdata[11:8] == `FBM_CMD_VER));

	////////////////////////////////////////////////////////////////////////////////
	// sequencing

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= FBM_IDLE;
		end else begin
			case (state_q)
				FBM_IDLE: begin
					if (job_wr && job_ok) begin
						case (wdata[11:8])
							`FBM_CMD_PLIST: state_q <= FBM_PCOLLECT;
							`FBM_CMD_DIAG: state_q <= FBM_DIAG;
							`FBM_CMD_STAT: state_q <= FBM_STWAIT;
							default: state_q <= FBM_REPLY;
						endcase
					end
				end
				FBM_PCOLLECT: begin
					if (wr && addr == `FBM_A_JOB && idx_q == `FBM_LIST_WORDS - 4'h1) begin
						state_q <= FBM_PWALK;
					end
				end
				FBM_PWALK: begin
					if (walk_hit) begin
						state_q <= FBM_PWAIT;
					end else if (walk_end) begin
						state_q <= FBM_IDLE;
					end
				end
				FBM_PWAIT: begin
					if (param_ack) begin
						state_q <= walk_end ? FBM_IDLE : FBM_PWALK;
					end
				end
				FBM_DIAG: state_q <= FBM_REPLY;
				FBM_STWAIT: begin
					if (status_ack) begin
						state_q <= FBM_REPLY;
					end
				end
				FBM_REPLY: begin
					if (rep_rd && idx_q == job_word_count - 4'h1) begin
						state_q <= FBM_IDLE;
					end
				end
				default: state_q <= FBM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_q <= 4'h0;
			idx_q <= 4'h0;
			job_word_count <= 4'h0;
			job_last_q <= 16'h0000;
		end else if (job_wr && job_ok) begin
			cmd_q <= wdata[11:8];
			idx_q <= 4'h0;
			job_last_q <= wdata;
			case (wdata[11:8])
				`FBM_CMD_PLIST, `FBM_CMD_ECHO: job_word_count <= `FBM_LIST_WORDS;
				`FBM_CMD_VER: job_word_count <= `FBM_VER_WORDS;
				default: job_word_count <= `FBM_ONE_WORD;
			endcase
		end else if ((state_q == FBM_PCOLLECT && wr && addr == `FBM_A_JOB) || rep_rd) begin
			idx_q <= idx_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// parameter list and forwarding

	always_ff @(posedge clock) begin
		for (int j = 0; j < 32; j++) begin
			if (rst) begin
				new_q[j] <= `FBM_PARAM_RST;
			end else if (state_q == FBM_PCOLLECT && wr && addr == `FBM_A_JOB
				&& idx_q == 4'(j / 4)) begin
				new_q[j] <= wdata[15 - 4 * (j % 4) -: 4];
			end
		end
	end

	always_ff @(posedge clock) begin
		for (int j = 0; j < 32; j++) begin
			if (rst) begin
				act_q[j] <= `FBM_PARAM_RST;
				echo_q[j] <= 4'h0;
			end else if (state_q == FBM_PWAIT && param_ack && walk_q == 5'(j)) begin
				act_q[j] <= new_q[j];
				echo_q[j] <= param_echo;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			walk_q <= 5'h01;
			param_req_q <= 1'b0;
			param_addr_q <= 5'h00;
			param_data_q <= 4'h0;
		end else begin
			case (state_q)
				FBM_PCOLLECT: walk_q <= 5'h01;
				FBM_PWALK: begin
					if (walk_hit) begin
						param_req_q <= 1'b1;
						param_addr_q <= walk_q;
						param_data_q <= new_q[walk_q];
					end else if (!walk_end) begin
						walk_q <= walk_q + 5'h01;
					end
				end
				FBM_PWAIT: begin
					if (param_ack) begin
						param_req_q <= 1'b0;
						if (!walk_end) begin
							walk_q <= walk_q + 5'h01;
						end
					end
				end
				default: param_req_q <= 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// error counters and slave status

	assign err_inc = xfer_fail && (slave_active || detected_slave_list[xfer_fail_addr]);

	fbm_err_mem u_err (
		.clock(clock),
		.rst(rst),
		.inc_en(err_inc),
		.inc_addr(xfer_fail_addr),
		.rc_en(job_wr && job_ok && wdata[11:8] == `FBM_CMD_DIAG),
		.rc_addr({1'b0, wdata[3:0]}),
		.rdata_q(err_rdata)
	);

	always_comb begin
		flags = 4'h0;
		flags[`FBM_ST_ADDR_VOL] = addr_volatile_flag;
		flags[`FBM_ST_PARITY] = parity_err_flag;
		flags[`FBM_ST_END_BIT] = end_bit_err_flag;
		flags[`FBM_ST_NVM_RD] = nvm_read_err_flag;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			status_req_q <= 1'b0;
			status_addr_q <= 5'h00;
			rep_word_q <= 16'h0000;
		end else if (job_wr && job_ok && wdata[11:8] == `FBM_CMD_STAT) begin
			status_req_q <= 1'b1;
			status_addr_q <= {1'b0, wdata[3:0]};
		end else if (state_q == FBM_STWAIT && status_ack) begin
			status_req_q <= 1'b0;
			rep_word_q <= {`FBM_MARK_RSP, flags, 8'h00};
		end else if (state_q == FBM_DIAG) begin
			rep_word_q <= {err_rdata, 8'h00};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reply words and register reads

	always_comb begin
		case (cmd_q)
			`FBM_CMD_ECHO: begin
				rep_word = {echo_q[{idx_q[2:0], 2'h0}], echo_q[{idx_q[2:0], 2'h1}],
					echo_q[{idx_q[2:0], 2'h2}], echo_q[{idx_q[2:0], 2'h3}]};
				if (idx_q == 4'h0) begin
					rep_word[15:12] = 4'h0;
				end
			end
			`FBM_CMD_VER: rep_word = 16'(FBM_VER_STR >> (16 * (14 - int'(idx_q))));
			default: rep_word = rep_word_q;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (rd) begin
			case (addr)
				`FBM_A_JOB: rdata_q <= job_last_q;
				`FBM_A_REPLY: rdata_q <= (state_q == FBM_REPLY) ? rep_word : 16'h0000;
				`FBM_A_STAT: rdata_q <= {8'h00, state_q != FBM_IDLE, state_q == FBM_REPLY,
					2'h0, job_word_count - idx_q};
				`FBM_A_ISTAT: rdata_q <= {14'h0000, istat_q};
				`FBM_A_IMASK: rdata_q <= {14'h0000, imask_q};
				default: rdata_q <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts

	always_ff @(posedge clock) begin
		if (rst) begin
			istat_q <= 2'h0;
			imask_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			istat_q[`FBM_IRQ_DONE] <= done_ev
				|| (istat_q[`FBM_IRQ_DONE] && !(wr && addr == `FBM_A_ISTAT && wdata[`FBM_IRQ_DONE]));
			istat_q[`FBM_IRQ_BAD] <= job_bad
				|| (istat_q[`FBM_IRQ_BAD] && !(wr && addr == `FBM_A_ISTAT && wdata[`FBM_IRQ_BAD]));
			if (wr && addr == `FBM_A_IMASK) begin
				imask_q <= wdata[1:0];
			end
			irq_q <= |(istat_q & imask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence param_start_s;
		state_q == FBM_PWALK && walk_hit;
	endsequence
	sequence param_done_s;
		param_req_q && param_ack;
	endsequence

	bad_job_a: assert property (job_bad |=> state_q == FBM_IDLE && istat_q[`FBM_IRQ_BAD]
		&& cmd_q == $past(cmd_q)) else $error("bad job changed state");
	param_diff_a: assert property (param_start_s |=> param_req_q
		&& param_data_q != act_q[param_addr_q]) else $error("unchanged parameter sent");
	param_echo_a: assert property (param_done_s |=> echo_q[$past(param_addr_q)]
		== $past(param_echo) && !param_req_q) else $error("echo not stored");
	ver_len_a: assert property (job_wr && job_ok && wdata[11:8] == `FBM_CMD_VER
		|=> state_q == FBM_REPLY && job_word_count == `FBM_VER_WORDS) else $error("version length");
	diag_reply_a: assert property (job_wr && job_ok && wdata[11:8] == `FBM_CMD_DIAG
		|=> ##1 rep_word_q[7:0] == 8'h00 && state_q == FBM_REPLY) else $error("diag reply");
	stat_reply_a: assert property (state_q == FBM_STWAIT && status_ack
		|=> rep_word_q[15:12] == `FBM_MARK_RSP && rep_word_q[11:8] == $past(flags)
		&& !status_req_q) else $error("status reply");
	irq_level_a: assert property (istat_q == $past(istat_q) && imask_q == $past(imask_q)
		|-> irq_q == |(istat_q & imask_q)) else $error("irq level");
	param_hold_a: assert property (param_req_q && !param_ack |=> param_req_q
		&& $stable(param_addr_q) && $stable(param_data_q)) else $error("param request dropped");
	skip_step_a: assert property (state_q == FBM_PWALK && !walk_hit && !walk_end
		|=> state_q == FBM_PWALK && walk_q == $past(walk_q) + 5'h01) else $error("walk no skip");
	status_hold_a: assert property (status_req_q && !status_ack |=> status_req_q
		&& $stable(status_addr_q)) else $error("status request dropped");
	idle_reply_a: assert property (rd && addr == `FBM_A_REPLY && state_q != FBM_REPLY
		|=> rdata_q == 16'h0000) else $error("reply read outside reply phase");
	done_flag_a: assert property (done_ev |=> istat_q[`FBM_IRQ_DONE]) else $error("done flag");
endmodule
`default_nettype wire

// file: hw/fbm_defines.svh
// constants of the field-bus parameter and diagnostic job handler
// Summary of operation
// - parameter list job takes 4-bit values four per word; only changed ones go out
// - echoes from parameter sends are kept and returned four per word from slave 0, whose slot reads 0
// - version job returns a name string ending in a version number x.yy
// - diagnostics job returns a slave's error count byte, then clears it
// - counter steps when a slave reply is missing or bad after the repeat
// - counter also steps for a non-activated slave in the detected slave list
// - error counter saturates at 255 and holds until cleared by a read
// - status job fetches and clears slave status; reply 0 then status bits 11-8
// - address-volatile flag also reported when stored and register address differ
// - parity flag reports a parity error since the last status read
// - end-bit flag reports an end bit error since the last status read
// - memory-read flag reports a failed read of the slave's non-volatile store
`ifndef FBM_DEFINES_SVH
`define FBM_DEFINES_SVH
`define FBM_A_JOB 5'h00
`define FBM_A_REPLY 5'h04
`define FBM_A_STAT 5'h08
`define FBM_A_ISTAT 5'h0c
`define FBM_A_IMASK 5'h10
`define FBM_MARK_REQ 4'h1
`define FBM_MARK_RSP 4'h0
`define FBM_CMD_PLIST 4'h1
`define FBM_CMD_ECHO 4'h3
`define FBM_CMD_VER 4'h4
`define FBM_CMD_DIAG 4'h5
`define FBM_CMD_STAT 4'h6
`define FBM_LIST_WORDS 4'h8
`define FBM_VER_WORDS 4'hf
`define FBM_ONE_WORD 4'h1
`define FBM_LAST_SLAVE 5'h1f
`define FBM_ERR_MAX 8'hff
`define FBM_PARAM_RST 4'hf
`define FBM_IRQ_DONE 0
`define FBM_IRQ_BAD 1
`define FBM_ST_ADDR_VOL 0
`define FBM_ST_PARITY 1
`define FBM_ST_END_BIT 2
`define FBM_ST_NVM_RD 3
`endif

// file: hw/fbm_pkg.sv
// types of the field-bus job handler
package fbm_pkg;
	typedef enum logic [2:0] {
		FBM_IDLE, FBM_PCOLLECT, FBM_PWALK, FBM_PWAIT, FBM_DIAG, FBM_STWAIT, FBM_REPLY
	} fbm_state_t;
	// arbitrary name and version text, 30 characters, two per reply word
	localparam logic [239:0] FBM_VER_STR = "FIELDBUS MASTER V         1.00";
endpackage

// file: hw/fbm_err_mem.sv
// per-slave saturating error counters with read-and-clear
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_err_mem (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// increment port
	input wire logic inc_en,
	input wire logic [4:0] inc_addr,
	// read and clear port
	input wire logic rc_en,
	input wire logic [4:0] rc_addr,
	output logic [7:0] rdata_q
);
	logic [7:0] cnt_q [0:31];

	always_ff @(posedge clock) begin
		for (int i = 0; i < 32; i++) begin
			if (rst) begin
				cnt_q[i] <= 8'h00;
			end else if (rc_en && rc_addr == 5'(i)) begin
				// an error in the clearing cycle is kept
				cnt_q[i] <= (inc_en && inc_addr == 5'(i)) ? 8'h01 : 8'h00;
			end else if (inc_en && inc_addr == 5'(i) && cnt_q[i] != `FBM_ERR_MAX) begin
				cnt_q[i] <= cnt_q[i] + 8'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (rc_en) begin
			rdata_q <= cnt_q[rc_addr];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	err_sat_a: assert property (inc_en && !rc_en && cnt_q[inc_addr] == `FBM_ERR_MAX
		|=> cnt_q[$past(inc_addr)] == `FBM_ERR_MAX) else $error("counter left saturation");
	err_inc_a: assert property (inc_en && !rc_en && cnt_q[inc_addr] != `FBM_ERR_MAX
		|=> cnt_q[$past(inc_addr)] == $past(cnt_q[inc_addr]) + 8'h01)
		else $error("counter did not step");
	err_clear_a: assert property (rc_en && !inc_en
		|=> cnt_q[$past(rc_addr)] == 8'h00 && rdata_q == $past(cnt_q[rc_addr]))
		else $error("read and clear failed");
endmodule
`default_nettype wire

// file: bench/fbm_link_model.sv
// link-side model of the field-bus slaves for parameter sends and status fetches
`timescale 1ns/100ps
`default_nettype none
module fbm_link_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// behaviour set by the bench
	input wire logic [1:0] lat,
	input wire logic [3:0] st_flags,
	// parameter link
	input wire logic param_req_q,
	input wire logic [4:0] param_addr_q,
	input wire logic [3:0] param_data_q,
	output logic param_ack,
	output logic [3:0] param_echo,
	// status link
	input wire logic status_req_q,
	input wire logic [4:0] status_addr_q,
	output logic status_ack,
	output logic [3:0] flags
);
	logic [1:0] p_cnt_q;
	logic [1:0] s_cnt_q;
	logic [3:0] echo_q;
	logic [3:0] flag_q;
	logic [4:0] saddr_q;
	logic [7:0] sends_q;
	logic [3:0] sent_q [32];
	// answer lines show the inverse outside the answer cycle
	assign param_echo = param_ack ? echo_q : ~echo_q;
	assign flags = status_ack ? flag_q : ~flag_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			param_ack <= 1'b0;
			status_ack <= 1'b0;
			p_cnt_q <= 2'h0;
			s_cnt_q <= 2'h0;
			sends_q <= 8'h00;
		end else begin
			param_ack <= 1'b0;
			status_ack <= 1'b0;
			if (param_req_q && !param_ack) begin
				p_cnt_q <= p_cnt_q + 2'h1;
				if (p_cnt_q == lat) begin
					p_cnt_q <= 2'h0;
					param_ack <= 1'b1;
					echo_q <= param_data_q ^ 4'ha;
					sent_q[param_addr_q] <= param_data_q;
					sends_q <= sends_q + 8'h01;
				end
			end
			if (status_req_q && !status_ack) begin
				s_cnt_q <= s_cnt_q + 2'h1;
				if (s_cnt_q == lat) begin
					s_cnt_q <= 2'h0;
					status_ack <= 1'b1;
					flag_q <= st_flags;
					saddr_q <= status_addr_q;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/fbm_top_tb.sv
// self-checking bench of the field-bus job handler
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_top_tb;
	import fbm_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata_q;
	logic irq_q, param_req_q, param_ack, status_req_q, status_ack;
	logic [4:0] param_addr_q, status_addr_q;
	logic [3:0] param_data_q, param_echo, flags;
	logic xfer_fail = 1'b0;
	logic [4:0] xfer_fail_addr = 5'h00;
	logic slave_active = 1'b0;
	logic [31:0] detected_slave_list = 32'h00000200;
	logic [1:0] lat = 2'h0;
	logic [3:0] st_flags = 4'h0;
	integer seed = 32'he9e6;
	int bad_count = 0;
	int num_checks = 0;
	logic [15:0] v, w;
	logic [7:0] n0, d;
	logic [3:0] act [32];
	logic [3:0] np [32];
	logic [3:0] ech [32];
	logic ch [32];
	logic [4:0] s;
	always #10 clock = ~clock;
	fbm_top u_fbm_top (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rdata_q), .irq_q(irq_q), .param_req_q(param_req_q),
		.param_addr_q(param_addr_q), .param_data_q(param_data_q), .param_ack(param_ack),
		.param_echo(param_echo), .status_req_q(status_req_q), .status_addr_q(status_addr_q),
		.status_ack(status_ack), .addr_volatile_flag(flags[0]), .parity_err_flag(flags[1]),
		.end_bit_err_flag(flags[2]), .nvm_read_err_flag(flags[3]), .xfer_fail(xfer_fail),
		.xfer_fail_addr(xfer_fail_addr), .slave_active(slave_active),
		.detected_slave_list(detected_slave_list));
	fbm_link_model u_fbm_link_model (.clock(clock), .rst(rst), .lat(lat), .st_flags(st_flags),
		.param_req_q(param_req_q), .param_addr_q(param_addr_q), .param_data_q(param_data_q),
		.param_ack(param_ack), .param_echo(param_echo), .status_req_q(status_req_q),
		.status_addr_q(status_addr_q), .status_ack(status_ack), .flags(flags));
	////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t %s got %h want %h", $time, m, g, e);
		end
	endtask
	task wrr(input logic [4:0] a, input logic [15:0] dat);
		@(posedge clock);
		addr <= a;
		wdata <= dat;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task rdr(input logic [4:0] a, output logic [15:0] dat);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 dat = rdata_q;
	endtask
	task wait_done;
		int i;
		v = 16'h0000;
		for (i = 0; i < 3000 && v[0] !== 1'b1; i++) rdr(`FBM_A_ISTAT, v);
		if (v[0] !== 1'b1) begin
			bad_count++;
			$display("BAD %0t job never finished", $time);
			stop_test();
		end
		chk({15'h0, irq_q}, 16'h0001, "irq on done");
		wrr(`FBM_A_ISTAT, 16'h0001);
	endtask
	task job(input logic [3:0] c, input logic [3:0] sl);
		wrr(`FBM_A_JOB, {`FBM_MARK_REQ, c, 4'h0, sl});
		wait_done();
	endtask
	task diag(input logic [3:0] sl, input logic [7:0] e);
		job(`FBM_CMD_DIAG, sl);
		rdr(`FBM_A_REPLY, v);
		chk(v, {e, 8'h00}, "diag count");
	endtask
	task fail(input logic [4:0] a, input logic ac, input int n);
		repeat (n) begin
			@(posedge clock);
			xfer_fail <= 1'b1;
			xfer_fail_addr <= a;
			slave_active <= ac;
			@(posedge clock);
			xfer_fail <= 1'b0;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 32; i++) begin
			act[i] = `FBM_PARAM_RST;
			ech[i] = 4'h0;
		end
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rdr(`FBM_A_STAT, v);
		chk(v, 16'h0000, "stat after reset");
		rdr(5'h14, v);
		chk(v, 16'h0000, "unmapped read");
		rdr(`FBM_A_REPLY, v);
		chk(v, 16'h0000, "idle reply read");
		wrr(`FBM_A_IMASK, 16'h0003);
		for (int r = 0; r < 2; r++) begin
			lat <= 2'(r * 3);
			n0 = u_fbm_link_model.sends_q;
			d = 8'h00;
			wrr(`FBM_A_JOB, {`FBM_MARK_REQ, `FBM_CMD_PLIST, 8'h00});
			for (int k = 0; k < 8; k++) begin
				w = 16'($random(seed));
				for (int j = 0; j < 4; j++) begin
					s = 5'(4 * k + j);
					np[s] = w[15 - 4 * j -: 4];
					ch[s] = (s != 5'h00) && (np[s] != act[s]);
					if (ch[s]) d = d + 8'h01;
				end
				wrr(`FBM_A_JOB, w);
			end
			wait_done();
			chk({8'h00, u_fbm_link_model.sends_q - n0}, {8'h00, d}, "send count");
			for (int i = 1; i < 32; i++) if (ch[i]) begin
				chk({12'h0, u_fbm_link_model.sent_q[i]}, {12'h0, np[i]}, "sent value");
				act[i] = np[i];
				ech[i] = np[i] ^ 4'ha;
			end
			$display("parameter round %0d done", r);
		end
		job(`FBM_CMD_ECHO, 4'h0);
		for (int k = 0; k < 8; k++) begin
			rdr(`FBM_A_REPLY, v);
			chk(v, {ech[4 * k], ech[4 * k + 1], ech[4 * k + 2], ech[4 * k + 3]}, "echo");
		end
		job(`FBM_CMD_VER, 4'h0);
		for (int k = 0; k < 15; k++) begin
			rdr(`FBM_A_REPLY, v);
			chk(v, FBM_VER_STR[239 - 16 * k -: 16], "version");
		end
		$display("list and version tests done");
		fail(5'h05, 1'b1, 3);
		fail(5'h09, 1'b0, 2);
		fail(5'h0c, 1'b0, 4);
		fail(5'h03, 1'b1, 260);
		diag(4'h5, 8'h03);
		diag(4'h9, 8'h02);
		diag(4'hc, 8'h00);
		diag(4'h3, `FBM_ERR_MAX);
		diag(4'h5, 8'h00);
		$display("diagnostics tests done");
		for (int i = 0; i < 5; i++) begin
			s = 5'($random(seed)) & 5'h0f;
			st_flags <= (i == 4) ? 4'hf : 4'($random(seed));
			lat <= 2'(i);
			job(`FBM_CMD_STAT, s[3:0]);
			chk({11'h0, u_fbm_link_model.saddr_q}, {11'h0, s}, "status slave");
			rdr(`FBM_A_REPLY, v);
			chk(v, {`FBM_MARK_RSP, st_flags, 8'h00}, "status reply");
		end
		$display("status tests done");
		fail(5'h05, 1'b1, 1);
		for (int c = 0; c < 17; c++) begin
			w = (c == 16) ? 16'h0505 : {`FBM_MARK_REQ, 4'(c), 8'h05};
			if (c == 1 || (c > 2 && c < 7)) continue;
			wrr(`FBM_A_JOB, w);
			rdr(`FBM_A_ISTAT, v);
			chk(v & 16'h0003, 16'h0002, "bad job flag");
			chk({15'h0, irq_q}, 16'h0001, "irq on bad job");
			wrr(`FBM_A_ISTAT, 16'h0002);
		end
		diag(4'h5, 8'h01);
		wrr(`FBM_A_IMASK, 16'h0000);
		wrr(`FBM_A_JOB, 16'h1205);
		repeat (3) @(posedge clock);
		#1 chk({15'h0, irq_q}, 16'h0000, "masked irq");
		wrr(`FBM_A_IMASK, 16'h0002);
		repeat (3) @(posedge clock);
		#1 chk({15'h0, irq_q}, 16'h0001, "unmasked irq");
		wrr(`FBM_A_ISTAT, 16'h0002);
		repeat (3) @(posedge clock);
		#1 chk({15'h0, irq_q}, 16'h0000, "cleared irq");
		$display("refusal and interrupt tests done");
		stop_test();
	end
endmodule
`default_nettype wire
